/* inc/epps_if.sv */
`timescale 1ns/1ns
interface epps_if;
	logic [7:0] addrIn;
	logic [7:0] dataIn;
	logic enable20N;
	logic enable2N;
	logic [7:0] readback;
	modport device (input addrIn, input dataIn, input enable20N, input enable2N,
		output readback);
	modport host (output addrIn, output dataIn, output enable20N, output enable2N,
		input readback);
endinterface : epps_if

/* inc/epps_pkg.sv */
package epps_pkg;
	localparam int AddrW = 8;
	localparam int DataW = 8;
	localparam int ClockHz = 125_000_000;
	localparam int LocationCount = 256;
	localparam int RepsPerLocation = 32;
	localparam int AddrTrueUs = 60;
	localparam int PulseStartUs = 155;
	localparam int PulseLenUs = 3000;
	localparam int CycleEndUs = 3250;
	localparam int Period20Us = 15000;
	localparam int Period2Us = 150000;
	localparam int HoldMs = 520;
	localparam int HostCycles = 35;
	localparam int HostAddrPort = 2;
	localparam int HostDataPort = 3;
	localparam int HostReadPort = 2;
	localparam int Enable20Bit = 7;
	localparam int Enable2Bit = 6;
	localparam int CyclesPerUs = ClockHz / 1_000_000;
	localparam int AddrTrueCyc = AddrTrueUs * CyclesPerUs;
	localparam int PulseStartCyc = PulseStartUs * CyclesPerUs;
	localparam int PulseEndCyc = (PulseStartUs + PulseLenUs) * CyclesPerUs;
	localparam int CycleEndCyc = CycleEndUs * CyclesPerUs;
	localparam int Period20Cyc = Period20Us * CyclesPerUs;
	localparam int Period2Cyc = Period2Us * CyclesPerUs;
	localparam int HoldCyc = HoldMs * 1000 * CyclesPerUs;
	localparam logic [7:0] EnPortReset = 8'hff;
endpackage : epps_pkg

/* tb/epps_checker.sv */
`timescale 1ns/1ns
module epps_checker #(
	parameter int AddrTrueCyc = 5,
	parameter int PulseStartCyc = 10,
	parameter int PulseEndCyc = 40,
	parameter int CycleEndCyc = 50,
	parameter int Period20Cyc = 100
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic [7:0] addrIn,
	input wire logic [7:0] dataIn,
	input wire logic [7:0] readback,
	input wire logic [7:0] memDataIn,
	input wire logic [7:0] memAddr,
	input wire logic [7:0] memDataOut,
	input wire logic memDataOeN,
	input wire logic supplyOn,
	input wire logic programPulseLine,
	input wire logic addrHighDrive
);
	localparam int LenM1 = PulseEndCyc - PulseStartCyc - 1;
	localparam int EndM1 = CycleEndCyc - 1;
	logic [31:0] sinceStart_r;
	logic started_r;
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			sinceStart_r <= 32'h0;
			started_r <= 1'b0;
		end else begin
			sinceStart_r <= $rose(supplyOn) ? 32'h1 : sinceStart_r + 32'h1;
			started_r <= started_r | $rose(supplyOn);
		end
	end
	cycle_start_a: assert property ($rose(supplyOn) |-> addrHighDrive && programPulseLine
		&& memAddr == ~addrIn) else $error("cycle start levels wrong");
	addr_true_a: assert property ($rose(supplyOn) |-> ##AddrTrueCyc memAddr == addrIn
		&& $past(memAddr) == ~addrIn) else $error("address not true in time");
	pulse_start_a: assert property ($rose(supplyOn) |-> ##PulseStartCyc
		!programPulseLine && $past(programPulseLine)) else $error("program pulse start late");
	pulse_len_a: assert property ($fell(programPulseLine) && supplyOn |-> ##LenM1
		!programPulseLine ##1 programPulseLine) else $error("program pulse length wrong");
	cycle_end_a: assert property ($rose(supplyOn) |-> ##EndM1 supplyOn ##1 !supplyOn
		&& !addrHighDrive && memDataOeN && !programPulseLine) else $error("cycle end wrong");
	period_a: assert property ($rose(supplyOn) && started_r |-> sinceStart_r == Period20Cyc)
		else $error("cycle period wrong");
	readback_a: assert property (!supplyOn[*3] |-> readback == ~$past(memDataIn))
		else $error("readback not true byte");
	data_gate_a: assert property (!memDataOeN |-> supplyOn && memDataOut == ~dataIn)
		else $error("data drivers open outside cycle");
endmodule : epps_checker

/* tb/eprom_program_pulse_sequencer_tb.sv */
`timescale 1ns/1ns
module eprom_program_pulse_sequencer_tb;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic start = 1'b0;
	logic [7:0] addr = 8'h00, data = 8'h00, memDataIn = 8'h00, memDataIn2 = 8'h00;
	logic busy, done, memDataOeN, supplyOn, programPulseLine, addrHighDrive, oe2, sup2, ppl2, ahd2;
	logic [7:0] readData, memAddr, memDataOut, memAddr2, memDataOut2;
	int error_cnt = 0;
	int comparisons = 0;
	localparam int AddrTrueT = 5;
	localparam int PulseStartT = 10;
	localparam int PulseEndT = 40;
	localparam int CycleEndT = 50;
	localparam int Period20T = 100;
	localparam int Period2T = 1000;
	localparam int HoldT = 300;
	logic hostSlow = 1'b0;
	epps_if bus();
	epps_if busB();
	epps_host #(.HoldCyc(HoldT), .CycleEndCyc(CycleEndT)) epps_host_i (.clock(clock),
		.rst(rst), .devSide(bus), .start(start), .addr(addr), .data(data),
		.slowMode(hostSlow), .busy(busy), .done(done), .readData(readData));
	epps_device #(.AddrTrueCyc(AddrTrueT), .PulseStartCyc(PulseStartT),
		.PulseEndCyc(PulseEndT), .CycleEndCyc(CycleEndT), .Period20Cyc(Period20T),
		.Period2Cyc(Period2T)) epps_device_i (.clock(clock), .rst(rst),
		.hostSide(bus), .memDataIn(memDataIn), .memAddr(memAddr), .memDataOut(memDataOut),
		.memDataOeN(memDataOeN), .supplyOn(supplyOn), .programPulseLine(programPulseLine),
		.addrHighDrive(addrHighDrive));
	// second device driven by the bench alone, for both duty modes and early release
	epps_device #(.AddrTrueCyc(AddrTrueT), .PulseStartCyc(PulseStartT),
		.PulseEndCyc(PulseEndT), .CycleEndCyc(CycleEndT), .Period20Cyc(Period20T),
		.Period2Cyc(Period2T)) epps_device_i2 (.clock(clock), .rst(rst),
		.hostSide(busB), .memDataIn(memDataIn2), .memAddr(memAddr2), .memDataOut(memDataOut2),
		.memDataOeN(oe2), .supplyOn(sup2), .programPulseLine(ppl2), .addrHighDrive(ahd2));
	epps_checker #(.AddrTrueCyc(AddrTrueT), .PulseStartCyc(PulseStartT),
		.PulseEndCyc(PulseEndT), .CycleEndCyc(CycleEndT), .Period20Cyc(Period20T))
		epps_checker_i (.clock(clock), .rst(rst), .addrIn(bus.addrIn),
		.dataIn(bus.dataIn), .readback(bus.readback), .memDataIn(memDataIn), .memAddr(memAddr),
		.memDataOut(memDataOut), .memDataOeN(memDataOeN), .supplyOn(supplyOn),
		.programPulseLine(programPulseLine), .addrHighDrive(addrHighDrive));
	initial begin
		forever #4 clock = ~clock;
	end
	task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic tick(int k);
		repeat (k) @(posedge clock);
		#1;
	endtask : tick
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : stop_test
	task automatic run(int mode, logic [7:0] a, logic [7:0] d, logic [7:0] r);
		int p;
		p = (mode == 1) ? Period2T : Period20T;
		@(posedge clock);
		busB.addrIn <= a;
		busB.dataIn <= d;
		memDataIn2 <= r;
		busB.enable20N <= (mode == 1);
		busB.enable2N <= (mode == 0);
		repeat (9) if (sup2 !== 1'b1) tick(1);
		check("addr inv", memAddr2, ~a);
		check("data", memDataOut2, ~d);
		check("ctl", {5'h00, oe2, ppl2, ahd2}, 8'h03);
		tick(5);
		check("addr true", memAddr2, a);
		tick(5);
		check("pulse", {7'h00, ppl2}, 8'h00);
		tick(30);
		check("pulse end", {7'h00, ppl2}, 8'h01);
		tick(10);
		check("quiet", {5'h00, oe2, ppl2, sup2}, 8'h04);
		tick(p - 51);
		check("gap", {7'h00, sup2}, 8'h00);
		tick(1);
		check("restart", {7'h00, sup2}, 8'h01);
		@(posedge clock);
		busB.enable20N <= 1'b1;
		busB.enable2N <= 1'b1;
		tick(47);
		check("run on", {7'h00, sup2}, 8'h01);
		tick(p);
		check("stopped", {7'h00, sup2}, 8'h00);
		check("readback", busB.readback, ~r);
		$display("test mode %0d done", mode);
	endtask : run
	initial begin
		void'($urandom(32'hba66ba75));
		busB.addrIn = 8'h00;
		busB.dataIn = 8'h00;
		busB.enable20N = 1'b1;
		busB.enable2N = 1'b1;
		repeat (4) @(posedge clock);
		rst <= 1'b0;
		fork
			begin
				@(posedge clock);
				addr <= 8'($urandom);
				data <= 8'($urandom);
				start <= 1'b1;
				@(posedge clock);
				start <= 1'b0;
				repeat (2000) if (done !== 1'b1) tick(1);
				check("done", {6'h00, busy, done}, 8'h01);
				check("host read", readData, 8'hff);
				$display("test host done");
			end
			begin
				run(0, 8'h00, 8'hff, 8'h0f);
				run(1, 8'hff, 8'h00, 8'hf0);
				run(2, 8'ha5, 8'h3c, 8'h81);
				repeat (3) run(int'($urandom_range(2)), 8'($urandom), 8'($urandom), 8'($urandom));
			end
		join
		stop_test();
	end
	initial begin
		#400000;
		error_cnt++;
		stop_test();
	end
endmodule : eprom_program_pulse_sequencer_tb

/* verilog/epps_device.sv */
`timescale 1ns/1ns
module epps_device #(
	parameter int AddrTrueCyc = epps_pkg::AddrTrueCyc,
	parameter int PulseStartCyc = epps_pkg::PulseStartCyc,
	parameter int PulseEndCyc = epps_pkg::PulseEndCyc,
	parameter int CycleEndCyc = epps_pkg::CycleEndCyc,
	parameter int Period20Cyc = epps_pkg::Period20Cyc,
	parameter int Period2Cyc = epps_pkg::Period2Cyc
) (
	input wire logic clock,
	input wire logic rst,
	epps_if.device hostSide,
	input wire logic [7:0] memDataIn,
	output logic [7:0] memAddr,
	output logic [7:0] memDataOut,
	output logic memDataOeN,
	output logic supplyOn,
	output logic programPulseLine,
	output logic addrHighDrive
);
	typedef enum logic [1:0] {
		EPPS_IDLE = 2'b01,
		EPPS_RUN = 2'b10
	} epps_state_t;

	typedef struct packed {
		epps_state_t state;
		logic [31:0] periodCnt;
		logic [31:0] cycleCnt;
		logic inCycle;
		logic [7:0] memAddr;
		logic [7:0] memDataOut;
		logic memDataOeN;
		logic supplyOn;
		logic programPulseLine;
		logic addrHighDrive;
		logic [7:0] readback;
	} epps_dev_t;

	// counter limits as 32-bit values, so no compare mixes widths
	localparam logic [31:0] AddrTrueLim = 32'(AddrTrueCyc);
	localparam logic [31:0] PulseStartLim = 32'(PulseStartCyc);
	localparam logic [31:0] PulseEndLim = 32'(PulseEndCyc);
	localparam logic [31:0] CycleLastCnt = 32'(CycleEndCyc - 1);
	localparam logic [31:0] Period20Lim = 32'(Period20Cyc);
	localparam logic [31:0] Period2Lim = 32'(Period2Cyc);

	// drivers off, supplies down, program line low
	localparam epps_dev_t ResetState = '{
		state: EPPS_IDLE,
		periodCnt: 32'h0,
		cycleCnt: 32'h0,
		inCycle: 1'b0,
		memAddr: 8'h00,
		memDataOut: 8'h00,
		memDataOeN: 1'b1,
		supplyOn: 1'b0,
		programPulseLine: 1'b0,
		addrHighDrive: 1'b0,
		readback: 8'h00
	};

	epps_dev_t cur_r;
	epps_dev_t cur_nxt;
	logic enable20;
	logic enable2;
	logic anyEnable;
	logic [31:0] periodLen;
	logic periodDue;
	logic cycleLast;
	logic pinsQuiet;

	// half-open window on the cycle counter
	function automatic logic in_span(
		input logic [31:0] cnt,
		input logic [31:0] lo,
		input logic [31:0] hi
	);
		return (cnt >= lo) && (cnt < hi);
	endfunction : in_span

	// both launch points must clear the same counters
	function automatic epps_dev_t launch(input epps_dev_t s);
		epps_dev_t r;
		r = s;
		r.periodCnt = 32'h0;
		r.cycleCnt = 32'h0;
		r.inCycle = 1'b1;
		return r;
	endfunction : launch

	function automatic logic [7:0] flip_byte(input logic [7:0] v, input logic inv);
		return inv ? ~v : v;
	endfunction : flip_byte

	assign enable20 = !hostSide.enable20N;
	assign enable2 = !hostSide.enable2N;
	assign anyEnable = enable20 || enable2;
	// 20 percent wins if both are low; the hotter choice was never asked for
	assign periodLen = enable20 ? Period20Lim : Period2Lim;
	assign periodDue = cur_r.periodCnt >= (periodLen - 32'h1);
	assign cycleLast = cur_r.cycleCnt == CycleLastCnt;
	// pins are only sensed once the drivers have let go for a full cycle
	assign pinsQuiet = !cur_r.inCycle && !cur_r.supplyOn;

	always_comb begin
		cur_nxt = cur_r;

		// period counter spans the whole period, cycle counter only the cycle
		case (cur_r.state)
			EPPS_IDLE: begin
				cur_nxt.inCycle = 1'b0;
				if (anyEnable) begin
					cur_nxt = launch(cur_r);
					cur_nxt.state = EPPS_RUN;
				end
			end
			EPPS_RUN: begin
				cur_nxt.periodCnt = cur_r.periodCnt + 32'h1;
				if (cur_r.inCycle) begin
					cur_nxt.cycleCnt = cur_r.cycleCnt + 32'h1;
					if (cycleLast) begin
						cur_nxt.inCycle = 1'b0;
					end
				end
				if (periodDue && !cur_r.inCycle) begin
					// a cycle in flight always finishes even if enable drops
					cur_nxt.periodCnt = 32'h0;
					if (anyEnable) begin
						cur_nxt = launch(cur_nxt);
					end else begin
						cur_nxt.state = EPPS_IDLE;
					end
				end else if (!anyEnable && !cur_r.inCycle) begin
					cur_nxt.state = EPPS_IDLE;
				end
			end
			default: begin
				cur_nxt.state = EPPS_IDLE;
				cur_nxt.inCycle = 1'b0;
			end
		endcase

		// pins follow the next cycle position, so each one is a flop
		if (cur_nxt.inCycle) begin
			// supplies, program line and address drive rise together
			cur_nxt.supplyOn = 1'b1;
			cur_nxt.addrHighDrive = 1'b1;
			cur_nxt.memDataOeN = 1'b0;
			cur_nxt.programPulseLine = !in_span(cur_nxt.cycleCnt, PulseStartLim,
				PulseEndLim);
			cur_nxt.memAddr = flip_byte(hostSide.addrIn,
				in_span(cur_nxt.cycleCnt, 32'h0, AddrTrueLim));
		end else begin
			// quiescent levels between cycles
			cur_nxt.supplyOn = 1'b0;
			cur_nxt.addrHighDrive = 1'b0;
			cur_nxt.memDataOeN = 1'b1;
			cur_nxt.programPulseLine = 1'b0;
			cur_nxt.memAddr = hostSide.addrIn;
		end

		cur_nxt.memDataOut = flip_byte(hostSide.dataIn, 1'b1);
		// readback holds its last value while the drivers may own the pins
		if (pinsQuiet) begin
			// pins still carry the complemented cell, blank cell reads ff
			cur_nxt.readback = flip_byte(memDataIn, 1'b1);
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			cur_r <= ResetState;
		end else begin
			cur_r <= cur_nxt;
		end
	end

	// every pin comes straight from the state register

	assign memAddr = cur_r.memAddr;
	assign memDataOut = cur_r.memDataOut;
	assign memDataOeN = cur_r.memDataOeN;
	assign supplyOn = cur_r.supplyOn;
	assign programPulseLine = cur_r.programPulseLine;
	assign addrHighDrive = cur_r.addrHighDrive;
	assign hostSide.readback = cur_r.readback;
endmodule : epps_device

/* verilog/epps_host.sv */
`timescale 1ns/1ns
module epps_host #(
	parameter int HoldCyc = epps_pkg::HoldCyc,
	parameter int CycleEndCyc = epps_pkg::CycleEndCyc
) (
	input wire logic clock,
	input wire logic rst,
	epps_if.host devSide,
	input wire logic start,
	input wire logic [7:0] addr,
	input wire logic [7:0] data,
	input wire logic slowMode,
	output logic busy,
	output logic done,
	output logic [7:0] readData
);
	typedef enum logic [2:0] {
		EPPH_IDLE = 3'b001,
		EPPH_HOLD = 3'b010,
		EPPH_SETTLE = 3'b100
	} epph_state_t;

	typedef struct packed {
		epph_state_t state;
		logic [31:0] cnt;
		logic [7:0] addrPort;
		logic [7:0] dataPort;
		logic [7:0] enPort;
		logic busy;
		logic done;
		logic [7:0] readData;
	} epph_t;

	epph_t cur_r;
	epph_t cur_nxt;

	always_comb begin
		cur_nxt = cur_r;
		cur_nxt.done = 1'b0;
		case (cur_r.state)
			EPPH_IDLE: begin
				if (start) begin
					cur_nxt.addrPort = addr;
					cur_nxt.dataPort = data;
					cur_nxt.enPort = epps_pkg::EnPortReset;
					cur_nxt.enPort[slowMode ? epps_pkg::Enable2Bit
						: epps_pkg::Enable20Bit] = 1'b0;
					cur_nxt.cnt = 32'h0;
					cur_nxt.busy = 1'b1;
					cur_nxt.state = EPPH_HOLD;
				end
			end
			EPPH_HOLD: begin
				cur_nxt.cnt = cur_r.cnt + 32'h1;
				if (cur_r.cnt == 32'(HoldCyc - 1)) begin
					cur_nxt.enPort = epps_pkg::EnPortReset;
					cur_nxt.cnt = 32'h0;
					cur_nxt.state = EPPH_SETTLE;
				end
			end
			EPPH_SETTLE: begin
				// device idles only after its last cycle ends
				cur_nxt.cnt = cur_r.cnt + 32'h1;
				if (cur_r.cnt == 32'(CycleEndCyc + 4)) begin
					cur_nxt.readData = devSide.readback;
					cur_nxt.busy = 1'b0;
					cur_nxt.done = 1'b1;
					cur_nxt.state = EPPH_IDLE;
				end
			end
			default: cur_nxt.state = EPPH_IDLE;
		endcase
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			cur_r <= '{state: EPPH_IDLE, cnt: 32'h0, addrPort: 8'h00, dataPort: 8'h00,
				enPort: epps_pkg::EnPortReset, busy: 1'b0, done: 1'b0, readData: 8'h00};
		end else begin
			cur_r <= cur_nxt;
		end
	end

	assign devSide.addrIn = cur_r.addrPort;
	assign devSide.dataIn = cur_r.dataPort;
	assign devSide.enable20N = cur_r.enPort[epps_pkg::Enable20Bit];
	assign devSide.enable2N = cur_r.enPort[epps_pkg::Enable2Bit];
	assign busy = cur_r.busy;
	assign done = cur_r.done;
	assign readData = cur_r.readData;
endmodule : epps_host
